/* logic/nmcs_core_regs.svh */
// constants of the nibble controller core: widths, reset values, field positions
// assumes inclusion by the core top level only; the fifo takes its sizes as parameters
`ifndef NMCS_CORE_REGS_SVH
`define NMCS_CORE_REGS_SVH

`define NMCS_PC_W          9
`define NMCS_PAGE_W        6
`define NMCS_ROM_WORDS     512
`define NMCS_PTR_W         6
`define NMCS_RAM_WORDS     32
`define NMCS_OPND_W        9
`define NMCS_OPC_W         5
`define NMCS_CMD_W         14
`define NMCS_FIFO_DEPTH    8
`define NMCS_INSTR_DIV     8
`define NMCS_PC_RST        9'h000
`define NMCS_NIB_RST       4'h0
`define NMCS_PTR_RST       6'h00
`define NMCS_SEG_RST       8'h00
`define NMCS_SKL_RST       1'b1
`define NMCS_DIGIT_TOP     4'hf
`define NMCS_DIGIT_BOT     4'h0
`define NMCS_FEAT_COUNTER  0
`define NMCS_FEAT_UNUSED   1
`define NMCS_FEAT_PORT     2
`define NMCS_FEAT_OUTSEL   3

`endif

/* logic/nmcs_pkg.sv */
// types shared by the nibble controller core and its command path
// assumes nothing beyond a SystemVerilog compiler
package nmcs_pkg;
    typedef enum logic [4:0] {
        OP_NOP,
        OP_ZERO_ACC,
        OP_ADD_CARRY,
        OP_STORE_ACC,
        OP_LOAD_PTR,
        OP_XCH_INC_SKIP,
        OP_XCH_DEC_SKIP,
        OP_SWAP_ACC_SHIFT,
        OP_LOAD_FEATURE,
        OP_SEG_FROM_RAM,
        OP_SEG_FROM_ROM,
        OP_READ_SEG_PORT,
        OP_LOAD_GP,
        OP_READ_GP_PORT,
        OP_JUMP,
        OP_JUMP_PAGE,
        OP_CALL,
        OP_RETURN
    } nmcs_op_t;
endpackage

/* logic/nmcs_stream_if.sv */
// valid/ready word stream between the command fifo and the core
// assumes both ends share one clock
`timescale 1ns/1ps
interface nmcs_stream_if #(parameter int WIDTH = 14);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* logic/nmcs_fifo.sv */
// first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module nmcs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic    clock_in,
    input  wire logic    srst_in,
    nmcs_stream_if.snk   wr,
    nmcs_stream_if.src   rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign wr.ready = (count_q != (AW+1)'(DEPTH));
    assign rd.valid = (count_q != '0);
    assign rd.data  = mem[rd_ptr_q];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == (AW)'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wr_ptr_q] <= wr.data;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= step(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= step(rd_ptr_q);
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

/* logic/nmcs_core_top.sv */
// architectural state and i/o of the nibble controller: counter, stack, ram, alu, ports, serial unit
// assumes one 50 MHz clock, decoded instructions arriving as commands, pins from outside the clock domain
//
// Summary of operation
// - 9-bit program counter addresses 512 8-bit words, seen as 8 pages of 64.
// - counter reloads on each instruction cycle that takes a command, by default with its value plus one.
// - two 9-bit return registers form a two-deep last-in first-out stack.
// - data memory is 128 bits: 4 rows of eight 4-bit digits, 6-bit pointer.
// - top 2 pointer bits pick the row, low 3 digit bits pick the digit.
// - exchange-increment/decrement skips only on digit wrap between 15 and 0.
// - the 4-bit digit field drives the nibble output port.
// - 4-bit adder writes the accumulator and sends carry to the overflow bit.
// - segment latch loads accumulator (high) with ram digit (low), or rom; byte port pins readable.
// - port-drive bit enables byte port drivers; clear means high impedance input.
// - general-purpose register drives the 4 bidirectional general-purpose pins.
// - swap instruction exchanges accumulator and serial register, copies carry to latch.
// - feature register written only by load-feature; its bit 1 does nothing.
// - counter mode decrements the serial register on each falling serial input edge.
// - counter mode: serial clock pin shows latch, serial output shows feature bit 3.
// - shift mode shifts left each instruction cycle, serial input into bit 0.
// - shift mode: bit 3 out when feature bit 3 set, else output stays 0.
// - shift mode: serial clock is latch ANDed with instruction clock.
// - initialisation clears counter, accumulator, pointer, carry, ports, features; ram kept.
// - after initialisation the serial clock pin gives one sync pulse per cycle.
`timescale 1ns/1ps
`include "nmcs_core_regs.svh"
module nmcs_core_top #(
    parameter int INSTR_DIV  = `NMCS_INSTR_DIV,
    parameter int FIFO_DEPTH = `NMCS_FIFO_DEPTH
) (
    input  wire logic                    clock_in,
    input  wire logic                    srst_in,
    input  wire logic                    cmd_valid_in,
    input  wire logic [`NMCS_CMD_W-1:0]  cmd_data_in,
    output logic                         cmd_ready_out,
    input  wire logic [7:0]              rom_data_in,
    output logic [`NMCS_PC_W-1:0]        program_counter_out,
    output logic [3:0]                   accumulator_out,
    output logic                         carry_out,
    output logic [3:0]                   feature_out,
    output logic [3:0]                   nibble_port_out,
    input  wire logic [7:0]              seg_port_in,
    output logic [7:0]                   seg_port_out,
    output logic [7:0]                   seg_port_oe_out,
    input  wire logic [3:0]              gp_port_in,
    output logic [3:0]                   gp_port_out,
    output logic [3:0]                   gp_port_oe_out,
    input  wire logic                    serial_in,
    output logic                         serial_out,
    output logic                         serial_clock_pin_out
);
    nmcs_stream_if #(.WIDTH(`NMCS_CMD_W)) cmd_wr ();
    nmcs_stream_if #(.WIDTH(`NMCS_CMD_W)) cmd_rd ();

    assign cmd_wr.valid  = cmd_valid_in;
    assign cmd_wr.data   = cmd_data_in;
    assign cmd_ready_out = cmd_wr.ready;

    nmcs_fifo #(.WIDTH(`NMCS_CMD_W), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .wr       (cmd_wr),
        .rd       (cmd_rd)
    );

    localparam int DW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

    logic [DW-1:0]             div_q;
    logic                      cyc_en;
    logic                      cyc_phase;
    logic [`NMCS_PC_W-1:0]     program_counter_q;
    logic [`NMCS_PC_W-1:0]     return_save_first_q;
    logic [`NMCS_PC_W-1:0]     return_save_second_q;
    logic [`NMCS_PTR_W-1:0]    ram_pointer_q;
    logic [3:0]                acc_q;
    logic                      carry_q;
    logic [3:0]                feature_select_q;
    logic [7:0]                segment_latch_q;
    logic [3:0]                gp_reg_q;
    logic [3:0]                shift_count_reg_q;
    logic                      clock_gate_latch_q;
    logic                      skip_q;
    logic                      so_q;
    logic                      sk_q;
    logic [3:0]                ram [0:`NMCS_RAM_WORDS-1];
    logic [1:0]                si_sync_q;
    logic                      si_prev_q;
    logic [7:0]                seg_meta_q;
    logic [7:0]                seg_sync_q;
    logic [3:0]                gp_meta_q;
    logic [3:0]                gp_sync_q;
    logic                      exec;
    logic                      consume;
    logic                      si_fall;
    logic [1:0]                ram_row_select;
    logic [3:0]                ram_digit_select;
    logic [3:0]                mem_rd;
    logic [4:0]                add_sum;
    logic [3:0]                digit_next;
    logic [`NMCS_OPND_W-1:0]   opnd;
    logic [`NMCS_PC_W-1:0]     pc_inc;
    nmcs_pkg::nmcs_op_t        op;

    // divider gives the instruction-cycle enable; the first half of each cycle is the clock phase
    assign cyc_en    = (div_q == (DW)'(INSTR_DIV-1));
    assign cyc_phase = (div_q < (DW)'(INSTR_DIV/2));

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            div_q <= '0;
        end else begin
            div_q <= cyc_en ? '0 : div_q + 1'b1;
        end
    end

    assign op      = nmcs_pkg::nmcs_op_t'(cmd_rd.data[`NMCS_CMD_W-1 -: `NMCS_OPC_W]);
    assign opnd    = cmd_rd.data[`NMCS_OPND_W-1:0];
    // one command per instruction cycle; a stall in the core backs up into the fifo
    assign cmd_rd.ready = cyc_en;
    assign consume      = cyc_en && cmd_rd.valid;
    assign exec         = consume && !skip_q;
    assign pc_inc       = program_counter_q + 1'b1;

    function automatic logic [4:0] ram_index(input logic [`NMCS_PTR_W-1:0] ptr);
        ram_index = {ptr[5:4], ptr[2:0]};
    endfunction

    assign ram_row_select   = ram_pointer_q[5:4];
    assign ram_digit_select = ram_pointer_q[3:0];
    assign mem_rd           = ram[ram_index(ram_pointer_q)];
    assign add_sum          = {1'b0, acc_q} + {1'b0, mem_rd} + {4'h0, carry_q};
    assign digit_next       = (op == nmcs_pkg::OP_XCH_INC_SKIP) ? ram_digit_select + 1'b1
                                                                : ram_digit_select - 1'b1;

    // program counter and return stack; rom is outside, addressed by the counter
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            program_counter_q    <= `NMCS_PC_RST;
            return_save_first_q  <= `NMCS_PC_RST;
            return_save_second_q <= `NMCS_PC_RST;
        end else if (consume) begin
            program_counter_q <= pc_inc;
            if (exec) begin
                case (op)
                    nmcs_pkg::OP_JUMP: begin
                        program_counter_q <= opnd;
                    end
                    nmcs_pkg::OP_JUMP_PAGE: begin
                        program_counter_q <= {program_counter_q[`NMCS_PC_W-1:`NMCS_PAGE_W],
                                              opnd[`NMCS_PAGE_W-1:0]};
                    end
                    nmcs_pkg::OP_CALL: begin
                        program_counter_q    <= opnd;
                        return_save_first_q  <= pc_inc;
                        return_save_second_q <= return_save_first_q;
                    end
                    nmcs_pkg::OP_RETURN: begin
                        program_counter_q   <= return_save_first_q;
                        return_save_first_q <= return_save_second_q;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // skip flag drops the next command; a skipped command still advances the counter
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            skip_q <= 1'b0;
        end else if (consume) begin
            skip_q <= 1'b0;
            if (exec && (op == nmcs_pkg::OP_XCH_INC_SKIP)) begin
                skip_q <= (ram_digit_select == `NMCS_DIGIT_TOP);
            end else if (exec && (op == nmcs_pkg::OP_XCH_DEC_SKIP)) begin
                skip_q <= (ram_digit_select == `NMCS_DIGIT_BOT);
            end
        end
    end

    // ram pointer
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ram_pointer_q <= `NMCS_PTR_RST;
        end else if (exec) begin
            if (op == nmcs_pkg::OP_LOAD_PTR) begin
                ram_pointer_q <= opnd[`NMCS_PTR_W-1:0];
            end else if (op == nmcs_pkg::OP_XCH_INC_SKIP || op == nmcs_pkg::OP_XCH_DEC_SKIP) begin
                ram_pointer_q <= {ram_row_select, digit_next};
            end
        end
    end

    // data memory is never reset so its contents survive initialisation
    always_ff @(posedge clock_in) begin
        if (exec) begin
            case (op)
                nmcs_pkg::OP_STORE_ACC,
                nmcs_pkg::OP_XCH_INC_SKIP,
                nmcs_pkg::OP_XCH_DEC_SKIP: begin
                    ram[ram_index(ram_pointer_q)] <= acc_q;
                end
                nmcs_pkg::OP_READ_SEG_PORT: begin
                    ram[ram_index(ram_pointer_q)] <= seg_sync_q[7:4];
                end
                default: begin
                end
            endcase
        end
    end

    // accumulator and overflow bit
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            acc_q   <= `NMCS_NIB_RST;
            carry_q <= 1'b0;
        end else if (exec) begin
            case (op)
                nmcs_pkg::OP_ZERO_ACC: begin
                    acc_q <= `NMCS_NIB_RST;
                end
                nmcs_pkg::OP_ADD_CARRY: begin
                    acc_q   <= add_sum[3:0];
                    carry_q <= add_sum[4];
                end
                nmcs_pkg::OP_XCH_INC_SKIP,
                nmcs_pkg::OP_XCH_DEC_SKIP: begin
                    acc_q <= mem_rd;
                end
                nmcs_pkg::OP_SWAP_ACC_SHIFT: begin
                    acc_q <= shift_count_reg_q;
                end
                nmcs_pkg::OP_READ_SEG_PORT: begin
                    acc_q <= seg_sync_q[3:0];
                end
                nmcs_pkg::OP_READ_GP_PORT: begin
                    acc_q <= gp_sync_q;
                end
                default: begin
                end
            endcase
        end
    end

    // feature register, segment latch, general-purpose register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            feature_select_q <= `NMCS_NIB_RST;
            segment_latch_q  <= `NMCS_SEG_RST;
            gp_reg_q         <= `NMCS_NIB_RST;
        end else if (exec) begin
            if (op == nmcs_pkg::OP_LOAD_FEATURE) begin
                feature_select_q <= opnd[3:0];
            end
            if (op == nmcs_pkg::OP_SEG_FROM_RAM) begin
                segment_latch_q <= {acc_q, mem_rd};
            end else if (op == nmcs_pkg::OP_SEG_FROM_ROM) begin
                segment_latch_q <= rom_data_in;
            end
            if (op == nmcs_pkg::OP_LOAD_GP) begin
                gp_reg_q <= acc_q;
            end
        end
    end

    // pin synchronisers; only the second stage is looked at
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            si_sync_q  <= 2'b11;
            si_prev_q  <= 1'b1;
            seg_meta_q <= 8'h00;
            seg_sync_q <= 8'h00;
            gp_meta_q  <= 4'h0;
            gp_sync_q  <= 4'h0;
        end else begin
            si_sync_q  <= {si_sync_q[0], serial_in};
            si_prev_q  <= si_sync_q[1];
            seg_meta_q <= seg_port_in;
            seg_sync_q <= seg_meta_q;
            gp_meta_q  <= gp_port_in;
            gp_sync_q  <= gp_meta_q;
        end
    end

    // pulses narrower than one clock cycle may be missed by the sampled edge detector
    assign si_fall = si_prev_q && !si_sync_q[1];

    // serial register: swap wins over shifting or counting in the same cycle
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            shift_count_reg_q  <= `NMCS_NIB_RST;
            clock_gate_latch_q <= `NMCS_SKL_RST;
        end else if (exec && op == nmcs_pkg::OP_SWAP_ACC_SHIFT) begin
            shift_count_reg_q  <= acc_q;
            clock_gate_latch_q <= carry_q;
        end else if (feature_select_q[`NMCS_FEAT_COUNTER]) begin
            if (si_fall) begin
                shift_count_reg_q <= shift_count_reg_q - 1'b1;
            end
        end else if (cyc_en) begin
            shift_count_reg_q <= {shift_count_reg_q[2:0], si_sync_q[1]};
        end
    end

    // serial output and clock pins; feature bit 1 is deliberately not decoded
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            so_q <= 1'b0;
            sk_q <= 1'b0;
        end else if (feature_select_q[`NMCS_FEAT_COUNTER]) begin
            so_q <= feature_select_q[`NMCS_FEAT_OUTSEL];
            sk_q <= clock_gate_latch_q;
        end else begin
            so_q <= feature_select_q[`NMCS_FEAT_OUTSEL] && shift_count_reg_q[3];
            sk_q <= clock_gate_latch_q && cyc_phase;
        end
    end

    assign program_counter_out  = program_counter_q;
    assign accumulator_out      = acc_q;
    assign carry_out            = carry_q;
    assign feature_out          = feature_select_q;
    assign nibble_port_out      = ram_digit_select;
    assign seg_port_out         = segment_latch_q;
    assign seg_port_oe_out      = {8{feature_select_q[`NMCS_FEAT_PORT]}};
    assign gp_port_out          = gp_reg_q;
    assign gp_port_oe_out       = 4'hf;
    assign serial_out           = so_q;
    assign serial_clock_pin_out = sk_q;

    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);

    AST_PC_STEP: assert property (
        consume && (skip_q || !(op inside {nmcs_pkg::OP_JUMP, nmcs_pkg::OP_JUMP_PAGE,
            nmcs_pkg::OP_CALL, nmcs_pkg::OP_RETURN}))
        |=> program_counter_q == $past(program_counter_q) + 1'b1)
        else $error("counter did not step by one");
    AST_CALL_RET: assert property (
        exec && op == nmcs_pkg::OP_CALL |=> return_save_first_q == $past(pc_inc)
        ##0 (return_save_second_q == $past(return_save_first_q)))
        else $error("call did not push return address");
    AST_WRAP_SKIP: assert property (
        exec && op == nmcs_pkg::OP_XCH_INC_SKIP
        |=> skip_q == ($past(ram_digit_select) == `NMCS_DIGIT_TOP))
        else $error("increment skip wrong");
    AST_NIBBLE_PORT: assert property (
        exec && op == nmcs_pkg::OP_LOAD_PTR |=> nibble_port_out == $past(opnd[3:0]))
        else $error("nibble port does not follow digit field");
    AST_ADDER: assert property (
        exec && op == nmcs_pkg::OP_ADD_CARRY
        |=> {carry_q, acc_q} == $past(add_sum))
        else $error("adder result or carry wrong");
    AST_PORT_DRIVE: assert property (
        exec && op == nmcs_pkg::OP_LOAD_FEATURE |=> seg_port_oe_out == {8{$past(opnd[2])}})
        else $error("byte port enable wrong");
    AST_SHIFT: assert property (
        cyc_en && !feature_select_q[0] && !(exec && op == nmcs_pkg::OP_SWAP_ACC_SHIFT)
        |=> shift_count_reg_q == {$past(shift_count_reg_q[2:0]), $past(si_sync_q[1])})
        else $error("shift step wrong");
    AST_COUNT: assert property (
        feature_select_q[0] && si_fall && !(exec && op == nmcs_pkg::OP_SWAP_ACC_SHIFT)
        |=> shift_count_reg_q == $past(shift_count_reg_q) - 1'b1)
        else $error("counter did not decrement");
    AST_SO_COUNTER: assert property (
        feature_select_q[0] && $stable(feature_select_q) |=> serial_out == $past(feature_select_q[3]))
        else $error("serial output not equal to feature bit 3");
    AST_SK_GATED: assert property (
        !feature_select_q[0] && !clock_gate_latch_q |=> !serial_clock_pin_out)
        else $error("serial clock pulsed with latch clear");
    AST_INIT: assert property (
        $past(srst_in) |-> program_counter_q == `NMCS_PC_RST && acc_q == `NMCS_NIB_RST
        && ram_pointer_q == `NMCS_PTR_RST && !carry_q && feature_select_q == `NMCS_NIB_RST)
        else $error("state not cleared by initialisation");
endmodule

/* sim/nmcs_serial_src.sv */
// serial input source for the core's counter and shift modes
// assumes the bench raises start_in once for each burst of falling edges
`timescale 1ns/1ps
module nmcs_serial_src #(
    parameter int HALF_NS = 80
) (
    input  wire logic       start_in,
    input  wire logic [3:0] count_in,
    output logic            serial_out
);
    // idles high so shift mode fills with ones
    initial serial_out = 1'b1;
    // each level lasts two instruction cycles at the bench divider, well above the one-clock shortest pulse
    always @(posedge start_in) begin
        repeat (count_in) begin
            #HALF_NS serial_out = 1'b0;
            #HALF_NS serial_out = 1'b1;
        end
    end
endmodule

/* sim/test_nibble_mcu_core_sio.sv */
// self-checking bench: command sequences into the core, pins and registers compared
// assumes the design files compiled first and the serial source model beside it
`timescale 1ns/1ps
module test_nibble_mcu_core_sio;
    // small divider so a 160 ns serial input period still gives two instruction cycles per level
    localparam int DIV = 2;
    logic       clk = 1'b0, srst = 1'b1, vld = 1'b0, sstart = 1'b0;
    logic       rdy, sin, cy, so, sck;
    logic [13:0] dat = 14'h0000;
    logic [7:0] rom = 8'h00, segi = 8'h00, sego, segoe;
    logic [3:0] gpi = 4'h0, gpo, gpoe, acc, feat, nib;
    logic [8:0] pc;
    int         err_total = 0, total_checks = 0, ncmd = 0, n;
    always #10 clk = ~clk;
    nmcs_core_top #(.INSTR_DIV(DIV), .FIFO_DEPTH(8)) u_nmcs_core_top (
        .clock_in(clk), .srst_in(srst), .cmd_valid_in(vld), .cmd_data_in(dat), .cmd_ready_out(rdy),
        .rom_data_in(rom), .program_counter_out(pc), .accumulator_out(acc), .carry_out(cy),
        .feature_out(feat), .nibble_port_out(nib), .seg_port_in(segi), .seg_port_out(sego),
        .seg_port_oe_out(segoe), .gp_port_in(gpi), .gp_port_out(gpo), .gp_port_oe_out(gpoe),
        .serial_in(sin), .serial_out(so), .serial_clock_pin_out(sck));
    nmcs_serial_src #(.HALF_NS(DIV * 40)) u_nmcs_serial_src (
        .start_in(sstart), .count_in(4'h3), .serial_out(sin));
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // entered and left at a falling edge; waits out execution of the word
    task automatic cmd(input nmcs_pkg::nmcs_op_t op, input logic [8:0] opd);
        for (n = 0; n < 50 && rdy !== 1'b1; n++) @(negedge clk);
        if (n == 50) begin
            err_total++;
            final_report();
        end
        vld = 1'b1;
        dat = {op, opd};
        @(negedge clk);
        vld = 1'b0;
        ncmd++;
        repeat (3 * DIV) @(negedge clk);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        // pins set early so the two-stage synchroniser has settled before the first read
        gpi  = 4'ha;
        chk("pc", 9'h000, pc);
        chk("seg", 8'h00, sego);
        chk("acc", 4'h0, acc);
        chk("carry", 1'b0, cy);
        chk("feature", 4'h0, feat);
        chk("nibble", 4'h0, nib);
        chk("gp", 4'h0, gpo);
        chk("seg_oe", 8'h00, segoe);
        chk("ready", 1'b1, rdy);
        repeat (DIV) @(negedge clk);
        n = 0;
        repeat (4 * DIV) begin
            @(negedge clk);
            n += int'(sck);
        end
        chk("sync_highs", 9'(2 * DIV), 9'(n));
        chk("serial_out", 1'b0, so);
        cmd(nmcs_pkg::OP_READ_GP_PORT, 9'h000);
        chk("acc", 4'ha, acc);
        cmd(nmcs_pkg::OP_LOAD_GP, 9'h000);
        chk("gp", 4'ha, gpo);
        chk("gp_oe", 4'hf, gpoe);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h005);
        cmd(nmcs_pkg::OP_STORE_ACC, 9'h000);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h00d);
        chk("nibble", 4'hd, nib);
        cmd(nmcs_pkg::OP_ZERO_ACC, 9'h000);
        chk("acc", 4'h0, acc);
        cmd(nmcs_pkg::OP_XCH_INC_SKIP, 9'h000);
        chk("alias_acc", 4'ha, acc);
        chk("nibble", 4'he, nib);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h00f);
        cmd(nmcs_pkg::OP_XCH_INC_SKIP, 9'h000);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h001);
        chk("skip_wrap", 4'h0, nib);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h007);
        cmd(nmcs_pkg::OP_XCH_INC_SKIP, 9'h000);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h002);
        chk("no_skip", 4'h2, nib);
        cmd(nmcs_pkg::OP_READ_GP_PORT, 9'h000);
        cmd(nmcs_pkg::OP_STORE_ACC, 9'h000);
        cmd(nmcs_pkg::OP_ADD_CARRY, 9'h000);
        chk("sum", 4'h4, acc);
        chk("carry", 1'b1, cy);
        chk("pc", 9'(ncmd), pc);
        cmd(nmcs_pkg::OP_LOAD_FEATURE, 9'h004);
        chk("seg_oe", 8'hff, segoe);
        rom = 8'h5c;
        segi = 8'h3c;
        cmd(nmcs_pkg::OP_SEG_FROM_ROM, 9'h000);
        chk("seg", 8'h5c, sego);
        cmd(nmcs_pkg::OP_READ_SEG_PORT, 9'h000);
        chk("acc", 4'hc, acc);
        cmd(nmcs_pkg::OP_SEG_FROM_RAM, 9'h000);
        chk("seg", 8'hc3, sego);
        cmd(nmcs_pkg::OP_LOAD_FEATURE, 9'h002);
        chk("seg_oe", 8'h00, segoe);
        cmd(nmcs_pkg::OP_JUMP, 9'h1c0);
        cmd(nmcs_pkg::OP_JUMP_PAGE, 9'h005);
        chk("pc", 9'h1c5, pc);
        cmd(nmcs_pkg::OP_CALL, 9'h020);
        cmd(nmcs_pkg::OP_CALL, 9'h040);
        chk("pc", 9'h040, pc);
        cmd(nmcs_pkg::OP_RETURN, 9'h000);
        chk("pc", 9'h021, pc);
        cmd(nmcs_pkg::OP_RETURN, 9'h000);
        chk("pc", 9'h1c6, pc);
        cmd(nmcs_pkg::OP_LOAD_FEATURE, 9'h008);
        chk("serial_out", 1'b1, so);
        cmd(nmcs_pkg::OP_SWAP_ACC_SHIFT, 9'h000);
        chk("acc", 4'hf, acc);
        cmd(nmcs_pkg::OP_LOAD_FEATURE, 9'h009);
        cmd(nmcs_pkg::OP_ZERO_ACC, 9'h000);
        cmd(nmcs_pkg::OP_SWAP_ACC_SHIFT, 9'h000);
        chk("serial_out", 1'b1, so);
        chk("serial_clock", 1'b1, sck);
        sstart = 1'b1;
        repeat (70) @(negedge clk);
        cmd(nmcs_pkg::OP_SWAP_ACC_SHIFT, 9'h000);
        chk("count", 4'hd, acc);
        cmd(nmcs_pkg::OP_LOAD_FEATURE, 9'h000);
        cmd(nmcs_pkg::OP_ZERO_ACC, 9'h000);
        cmd(nmcs_pkg::OP_ADD_CARRY, 9'h000);
        chk("sum", 4'h4, acc);
        chk("carry", 1'b0, cy);
        cmd(nmcs_pkg::OP_SWAP_ACC_SHIFT, 9'h000);
        n = 0;
        repeat (4 * DIV) begin
            @(negedge clk);
            n += int'(sck);
        end
        chk("gated_highs", 9'h000, 9'(n));
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h000);
        cmd(nmcs_pkg::OP_XCH_DEC_SKIP, 9'h000);
        cmd(nmcs_pkg::OP_LOAD_PTR, 9'h003);
        chk("dec_wrap", 4'hf, nib);
        final_report();
    end
endmodule
